// ---- far_pkg.sv ----
// Package for the fault auto-retry controller: register map, fault classes, timing
package far_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses on APB)
   // ----------------------------------------------------------------
   localparam logic [7:0]  FAR_ADDR_CLASS_SEL   = 8'h00;
   localparam logic [7:0]  FAR_ADDR_ATT_LIMIT   = 8'h04;
   localparam logic [7:0]  FAR_ADDR_WAIT_TIME   = 8'h08;
   localparam logic [7:0]  FAR_ADDR_SUCC_CNT    = 8'h0C;
   localparam logic [7:0]  FAR_ADDR_CTRL        = 8'h10;
   localparam logic [7:0]  FAR_ADDR_STATUS      = 8'h14;

   // ----------------------------------------------------------------
   // Reset values and limits
   // ----------------------------------------------------------------
   localparam logic [7:0]  FAR_CLASS_SEL_RST    = 8'h00;
   localparam logic [7:0]  FAR_ATT_LIMIT_RST    = 8'h00;
   localparam logic [7:0]  FAR_WAIT_TIME_RST    = 8'h01;
   localparam logic [15:0] FAR_SUCC_CNT_RST     = 16'h0000;
   localparam logic [7:0]  FAR_WAIT_TIME_MAX    = 8'h0A;
   localparam logic [7:0]  FAR_LIMIT_LO_MAX     = 8'h0A;
   localparam logic [7:0]  FAR_LIMIT_HI_MIN     = 8'h65;
   localparam logic [7:0]  FAR_LIMIT_HI_MAX     = 8'h6E;
   localparam logic [7:0]  FAR_LIMIT_HI_OFFS    = 8'h64;
   localparam logic [7:0]  FAR_CLASS_SEL_MAX    = 8'h05;
   localparam logic [15:0] FAR_COAST_DISABLED   = 16'h270F;

   // CTRL fields
   localparam int          FAR_CTRL_ACT_NEG_BIT = 0;
   localparam logic [31:0] FAR_CTRL_RST         = 32'h0000_0000;

   // STATUS fields
   localparam int          FAR_ST_TRIP_BIT      = 0;
   localparam int          FAR_ST_ACTIVE_BIT    = 1;
   localparam int          FAR_ST_LIMIT_BIT     = 2;
   localparam int          FAR_ST_FAILS_LSB     = 8;
   localparam int          FAR_ST_FIRST_LSB     = 16;

   // ----------------------------------------------------------------
   // Timing: one second at 40 MHz
   // ----------------------------------------------------------------
   localparam int          FAR_CLK_HZ           = 40_000_000;
   localparam int          FAR_SECOND_S         = 1;
   localparam int          FAR_SECOND_CYC       = FAR_SECOND_S * FAR_CLK_HZ;
   localparam int          FAR_SUCC_FACTOR      = 4;

   // ----------------------------------------------------------------
   // Fault class codes (5-bit code, 0 = none)
   // ----------------------------------------------------------------
   localparam logic [4:0]  FLT_NONE             = 5'h00;
   localparam logic [4:0]  FLT_OVERCURRENT_A    = 5'h01;
   localparam logic [4:0]  FLT_OVERCURRENT_B    = 5'h02;
   localparam logic [4:0]  FLT_OVERCURRENT_C    = 5'h03;
   localparam logic [4:0]  FLT_EXCESS_VOLT_A    = 5'h04;
   localparam logic [4:0]  FLT_EXCESS_VOLT_B    = 5'h05;
   localparam logic [4:0]  FLT_EXCESS_VOLT_C    = 5'h06;
   localparam logic [4:0]  FLT_MOTOR_THERMAL    = 5'h07;
   localparam logic [4:0]  FLT_DRIVE_THERMAL    = 5'h08;
   localparam logic [4:0]  FLT_MOMENTARY_LOSS   = 5'h09;
   localparam logic [4:0]  FLT_UNDERVOLTAGE     = 5'h0A;
   localparam logic [4:0]  FLT_BRAKE_CIRCUIT    = 5'h0B;
   localparam logic [4:0]  FLT_GROUND_LEAK      = 5'h0C;
   localparam logic [4:0]  FLT_EXT_OVERHEAT     = 5'h0D;
   localparam logic [4:0]  FLT_STALL_LIMIT      = 5'h0E;
   localparam logic [4:0]  FLT_ACCESSORY_CARD   = 5'h0F;
   localparam logic [4:0]  FLT_ACCESSORY_SLOT   = 5'h10;
   localparam logic [4:0]  FLT_PARAM_STORAGE    = 5'h11;
   localparam logic [4:0]  FLT_THERMISTOR       = 5'h12;
   localparam logic [4:0]  FLT_CURRENT_LIMIT    = 5'h13;
   localparam logic [4:0]  FLT_LINK_COMM        = 5'h14;
   localparam logic [4:0]  FLT_INPUT_PHASE      = 5'h15;
   localparam logic [4:0]  FLT_LOSS_OF_SYNC     = 5'h16;
   localparam logic [4:0]  FLT_LOOP_CONTROL     = 5'h17;
   localparam logic [4:0]  FLT_ATTEMPT_LIMIT    = 5'h18;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       valid;
      logic [4:0] code;
      logic       test_init;
      logic       at_power_on;
   } far_fault_t;

   typedef struct packed {
      logic reset_fault;
      logic restart;
      logic flying_restart;
   } far_cmd_t;

   typedef enum logic [3:0] {
      FAR_IDLE    = 4'b0001,
      FAR_WAIT    = 4'b0010,
      FAR_PROBE   = 4'b0100,
      FAR_LOCKED  = 4'b1000
   } far_state_t;

endpackage

// ---- far_retry_ctrl.sv ----
// Fault auto-retry controller for a motor drive, APB register slave
//
// Behaviour
// - Retry limit zero disables retry; any other allowed limit enables it.
// - Limit 1..10 gives that many retries, fault output low during retry.
// - Limit 101..110 gives limit minus 100 retries, fault output high during retry.
// - After eligible trip, wait programmed time, clear fault, restart at start frequency.
// - Wait time 0..10 s, initial 1 s, counted from trip to retry.
// - Failures beyond limit raise attempt-limit trip; stay tripped, no more retries.
// - Fault-free for over four wait times after restart counts as success, counter plus one.
// - Success clears consecutive failure count.
// - Success counter reads cumulative successes; writing zero clears it.
// - Retry-active output during retry, positive or negative logic selectable.
// - Only faults enabled by class selection are retried; others trip outright.
// - Selection 0 retries all classes; 4 all but thermal, overheat, thermistor.
// - Sel 1 overcurrent+sync, 2 overvoltage, 3 both, 5 overcurrent a,c+sync.
// - A retry sequence ending in trip keeps only its first fault stored.
// - Retry fault reset keeps thermal and brake duty data, unlike power-on reset.
// - Parameter storage fault at power-on is never retried.
// - Ineligible fault during wait abandons retry, fault indication stays.
// - Faults from the test initiation function are never retried.
// - Coast time not 9999 makes each retry restart a flying restart.
`timescale 1ns/1ps
module far_retry_ctrl
   import far_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Drive fault detection (same clock)
   input  wire far_fault_t  fault_i,
   input  wire logic [15:0] restart_coast_time_i,
   // Drive run/restart control
   output far_cmd_t         cmd_o,
   output logic             keep_thermal_data_o,
   output logic             fault_out_o,
   output logic             retry_active_out_o,
   output logic             attempt_limit_trip_o,
   output logic [4:0]       stored_fault_o
);

   // ----------------------------------------------------------------
   // Reset synchroniser
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_reg;
   logic       rst_b;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_b = rst_sync_reg[1];

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic class_eligible(input logic [7:0] sel, input logic [4:0] code);
      logic oc;
      logic ov;
      logic sync;
      logic thermal;
      logic listed;
      oc      = (code == FLT_OVERCURRENT_A) || (code == FLT_OVERCURRENT_B) || (code == FLT_OVERCURRENT_C);
      ov      = (code == FLT_EXCESS_VOLT_A) || (code == FLT_EXCESS_VOLT_B) || (code == FLT_EXCESS_VOLT_C);
      sync    = (code == FLT_LOSS_OF_SYNC);
      thermal = (code == FLT_MOTOR_THERMAL) || (code == FLT_DRIVE_THERMAL)
             || (code == FLT_EXT_OVERHEAT) || (code == FLT_THERMISTOR);
      listed  = (code >= FLT_OVERCURRENT_A) && (code <= FLT_LOOP_CONTROL);
      case (sel)
         8'h00:   class_eligible = listed;
         8'h01:   class_eligible = oc || sync;
         8'h02:   class_eligible = ov;
         8'h03:   class_eligible = oc || ov || sync;
         8'h04:   class_eligible = listed && !thermal;
         8'h05:   class_eligible = (code == FLT_OVERCURRENT_A) || (code == FLT_OVERCURRENT_C) || sync;
         default: class_eligible = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] allowed_retries(input logic [7:0] lim);
      if (lim >= FAR_LIMIT_HI_MIN && lim <= FAR_LIMIT_HI_MAX) begin
         allowed_retries = lim - FAR_LIMIT_HI_OFFS;
      end else if (lim <= FAR_LIMIT_LO_MAX) begin
         allowed_retries = lim;
      end else begin
         allowed_retries = 8'h00;
      end
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      far_state_t  fsm;
      logic [7:0]  class_sel;
      logic [7:0]  att_limit;
      logic [7:0]  wait_time;
      logic [15:0] succ_cnt;
      logic        act_neg;
      logic [7:0]  fails;
      logic [3:0]  secs;
      logic [5:0]  probe_secs;
      logic [25:0] tick_cnt;
      logic [4:0]  first_fault;
      logic        tripped;
      logic        limit_trip;
      far_cmd_t    cmd;
      logic        fault_out;
      logic        active_out;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } far_regs_t;

   far_regs_t st_reg;
   far_regs_t st_next;

   logic       tick;
   logic       eligible;
   logic       retry_on;
   logic [7:0] allow;
   logic       active;
   logic       hi_mode;
   logic       wr;
   logic       rd;
   logic       addr_ok;

   always_comb begin
      st_next  = st_reg;
      tick     = (st_reg.tick_cnt == 26'(FAR_SECOND_CYC - 1));
      allow    = allowed_retries(st_reg.att_limit);
      retry_on = (allow != 8'h00);
      hi_mode  = (st_reg.att_limit >= FAR_LIMIT_HI_MIN);
      eligible = fault_i.valid && retry_on
              && class_eligible(st_reg.class_sel, fault_i.code)
              && !fault_i.test_init
              && !((fault_i.code == FLT_PARAM_STORAGE) && fault_i.at_power_on);
      wr       = psel_i && penable_i && pwrite_i && !st_reg.pready;
      rd       = psel_i && !penable_i && !pwrite_i;
      addr_ok  = (paddr_i <= FAR_ADDR_STATUS) && (paddr_i[1:0] == 2'b00);

      // One-second time base
      st_next.tick_cnt = tick ? 26'h000_0000 : st_reg.tick_cnt + 26'h000_0001;
      st_next.cmd      = '0;

      // ------------------------------------------------------------
      // Retry sequencer
      // ------------------------------------------------------------
      case (st_reg.fsm)
         FAR_IDLE: begin
            if (fault_i.valid) begin
               st_next.tripped     = 1'b1;
               st_next.first_fault = fault_i.code;
               st_next.fails       = 8'h00;
               if (eligible) begin
                  st_next.fsm      = FAR_WAIT;
                  st_next.secs     = 4'h0;
                  st_next.tick_cnt = 26'h000_0000;
               end
            end
         end
         FAR_WAIT: begin
            if (fault_i.valid && !eligible) begin
               st_next.fsm = FAR_LOCKED;
            end else if (st_reg.secs >= st_reg.wait_time[3:0]) begin
               st_next.cmd.reset_fault    = 1'b1;
               st_next.cmd.restart        = 1'b1;
               st_next.cmd.flying_restart = (restart_coast_time_i != FAR_COAST_DISABLED);
               st_next.tripped            = 1'b0;
               st_next.fsm                = FAR_PROBE;
               st_next.probe_secs         = 6'h00;
               st_next.tick_cnt           = 26'h000_0000;
            end else if (tick) begin
               st_next.secs = st_reg.secs + 4'h1;
            end
         end
         FAR_PROBE: begin
            if (fault_i.valid) begin
               st_next.tripped = 1'b1;
               st_next.fails   = st_reg.fails + 8'h01;
               if (st_reg.fails + 8'h01 >= allow) begin
                  st_next.limit_trip = 1'b1;
                  st_next.fsm        = FAR_LOCKED;
               end else if (eligible) begin
                  st_next.fsm      = FAR_WAIT;
                  st_next.secs     = 4'h0;
                  st_next.tick_cnt = 26'h000_0000;
               end else begin
                  st_next.fsm = FAR_LOCKED;
               end
            end else if (st_reg.probe_secs > {st_reg.wait_time[3:0], 2'b00}) begin
               st_next.succ_cnt = st_reg.succ_cnt + 16'h0001;
               st_next.fails    = 8'h00;
               st_next.fsm      = FAR_IDLE;
            end else if (tick) begin
               st_next.probe_secs = st_reg.probe_secs + 6'h01;
            end
         end
         FAR_LOCKED: begin
            st_next.tripped = 1'b1;
         end
         default: st_next.fsm = FAR_IDLE;
      endcase

      // Outputs
      active = (st_next.fsm == FAR_WAIT) || (st_next.fsm == FAR_PROBE);
      st_next.active_out = active ^ st_reg.act_neg;
      if (active) begin
         // Held for the whole retry, restart included, so the alarm never flickers
         st_next.fault_out = hi_mode;
      end else begin
         st_next.fault_out = st_next.tripped;
      end

      // ------------------------------------------------------------
      // APB slave: one wait state, read data latched in setup
      // ------------------------------------------------------------
      st_next.pready  = psel_i && penable_i && !st_reg.pready;
      st_next.pslverr = psel_i && penable_i && !st_reg.pready && !addr_ok;
      if (rd) begin
         case (paddr_i)
            FAR_ADDR_CLASS_SEL: st_next.prdata = {24'h00_0000, st_reg.class_sel};
            FAR_ADDR_ATT_LIMIT: st_next.prdata = {24'h00_0000, st_reg.att_limit};
            FAR_ADDR_WAIT_TIME: st_next.prdata = {24'h00_0000, st_reg.wait_time};
            FAR_ADDR_SUCC_CNT:  st_next.prdata = {16'h0000, st_reg.succ_cnt};
            FAR_ADDR_CTRL:      st_next.prdata = {31'h0000_0000, st_reg.act_neg};
            FAR_ADDR_STATUS:    st_next.prdata = {11'h000, st_reg.first_fault, st_reg.fails,
                                                  5'h00, st_reg.limit_trip, active, st_reg.tripped};
            default:            st_next.prdata = 32'h0000_0000;
         endcase
      end
      if (wr) begin
         case (paddr_i)
            FAR_ADDR_CLASS_SEL: begin
               if (pwdata_i[7:0] <= FAR_CLASS_SEL_MAX) begin
                  st_next.class_sel = pwdata_i[7:0];
               end
            end
            FAR_ADDR_ATT_LIMIT: begin
               if (pwdata_i[7:0] <= FAR_LIMIT_LO_MAX
                   || (pwdata_i[7:0] >= FAR_LIMIT_HI_MIN && pwdata_i[7:0] <= FAR_LIMIT_HI_MAX)) begin
                  st_next.att_limit = pwdata_i[7:0];
               end
            end
            FAR_ADDR_WAIT_TIME: begin
               if (pwdata_i[7:0] <= FAR_WAIT_TIME_MAX) begin
                  st_next.wait_time = pwdata_i[7:0];
               end
            end
            FAR_ADDR_SUCC_CNT: begin
               // A success in this same cycle is dropped; clear is a deliberate act
               if (pwdata_i[15:0] == 16'h0000) begin
                  st_next.succ_cnt = 16'h0000;
               end
            end
            FAR_ADDR_CTRL: begin
               st_next.act_neg = pwdata_i[FAR_CTRL_ACT_NEG_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b) begin
      if (!rst_b) begin
         st_reg           <= '0;
         st_reg.fsm       <= FAR_IDLE;
         st_reg.class_sel <= FAR_CLASS_SEL_RST;
         st_reg.att_limit <= FAR_ATT_LIMIT_RST;
         st_reg.wait_time <= FAR_WAIT_TIME_RST;
         st_reg.succ_cnt  <= FAR_SUCC_CNT_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata_o             = st_reg.prdata;
   assign pready_o             = st_reg.pready;
   assign pslverr_o            = st_reg.pslverr;
   assign cmd_o                = st_reg.cmd;
   assign keep_thermal_data_o  = st_reg.cmd.reset_fault;
   assign fault_out_o          = st_reg.fault_out;
   assign retry_active_out_o   = st_reg.active_out;
   assign attempt_limit_trip_o = st_reg.limit_trip;
   assign stored_fault_o       = st_reg.first_fault;

endmodule

// ---- far_retry_sva.sv ----
// Port checker for the fault auto-retry controller
`timescale 1ns/1ps
module far_retry_sva
   import far_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   // Register bus
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pready_o,
   input  wire logic        pslverr_o,
   // Drive side
   input  wire logic [15:0] restart_coast_time_i,
   input  wire far_cmd_t    cmd_o,
   input  wire logic        keep_thermal_data_o,
   input  wire logic        attempt_limit_trip_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   // ----
   // Bus phases
   // ----
   sequence s_setup; psel_i && !penable_i; endsequence
   sequence s_access; psel_i && penable_i; endsequence
   property p_answer; s_setup ##1 s_access |=> pready_o; endproperty
   property p_ready_in_access; pready_o |-> psel_i && penable_i; endproperty
   property p_err_with_ready; pslverr_o |-> pready_o; endproperty
   // ----
   // Retry commands
   // ----
   property p_restart_pulse; cmd_o.restart |=> !cmd_o.restart; endproperty
   property p_restart_resets; cmd_o.restart |-> cmd_o.reset_fault && keep_thermal_data_o; endproperty
   property p_keep_with_reset; keep_thermal_data_o |-> cmd_o.reset_fault; endproperty
   property p_flying;
      cmd_o.restart && restart_coast_time_i != FAR_COAST_DISABLED |-> cmd_o.flying_restart;
   endproperty
   property p_plain;
      cmd_o.restart && restart_coast_time_i == FAR_COAST_DISABLED |-> !cmd_o.flying_restart;
   endproperty
   // Once locked, nothing short of reset brings the drive back
   property p_locked; attempt_limit_trip_o |=> attempt_limit_trip_o && !cmd_o.restart; endproperty
   a_answer: assert property (p_answer) else $error("pready late or missing");
   a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
   a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
   a_restart_pulse: assert property (p_restart_pulse) else $error("restart longer than one cycle");
   a_restart_resets: assert property (p_restart_resets) else $error("restart without kept reset");
   a_keep_with_reset: assert property (p_keep_with_reset) else $error("keep data without reset");
   a_flying: assert property (p_flying) else $error("flying restart missing");
   a_plain: assert property (p_plain) else $error("unexpected flying restart");
   a_locked: assert property (p_locked) else $error("attempt limit trip not held");
endmodule
bind far_retry_ctrl far_retry_sva far_retry_sva_i (
   .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .restart_coast_time_i(restart_coast_time_i),
   .cmd_o(cmd_o), .keep_thermal_data_o(keep_thermal_data_o), .attempt_limit_trip_o(attempt_limit_trip_o));

// ---- far_drive_model.sv ----
// Drive-side fault source and restart observer
`timescale 1ns/1ps
module far_drive_model
   import far_pkg::*;
(
   // Clock
   input  wire logic       clk_i,
   // Bench requests
   input  wire logic       fire_i,
   input  wire far_fault_t req_i,
   // Controller side
   input  wire far_cmd_t   cmd_i,
   output far_fault_t      fault_o,
   output int              restarts_o
);
   initial fault_o = '0;
   initial restarts_o = 0;
   always @(posedge clk_i) begin
      // Fields churn between faults so nothing rides on stale values
      fault_o <= fire_i ? req_i : '{1'b0, ~fault_o.code, ~fault_o.test_init, ~fault_o.at_power_on};
      if (cmd_i.restart)
         restarts_o <= restarts_o + 1;
   end
endmodule

// ---- far_retry_ctrl_test.sv ----
// Self-checking bench for the fault auto-retry controller
`timescale 1ns/1ps
module far_retry_ctrl_test import far_pkg::*;;
   logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, seed = 32'h37b2_1ea8;
   logic pready, pslverr, keep, fout, act, ltrip;
   logic [15:0] coast = 16'h270F;
   logic [4:0] stored;
   far_fault_t fault, req = '0;
   far_cmd_t cmd;
   int failures = 0, check_count = 0, restarts;
   always #12.5 clk = ~clk;
   far_retry_ctrl far_retry_ctrl_i (.core_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .fault_i(fault), .restart_coast_time_i(coast), .cmd_o(cmd),
      .keep_thermal_data_o(keep), .fault_out_o(fout), .retry_active_out_o(act),
      .attempt_limit_trip_o(ltrip), .stored_fault_o(stored));
   far_drive_model far_drive_model_i (.clk_i(clk), .fire_i(fire), .req_i(req), .cmd_i(cmd),
      .fault_o(fault), .restarts_o(restarts));
   // ----
   // Helpers
   // ----
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function bit elig(int sel, int c);
      case (sel)
         0: return c >= 1 && c <= 23;
         1: return c inside {1, 2, 3, 22};
         2: return c inside {4, 5, 6};
         3: return c inside {1, 2, 3, 4, 5, 6, 22};
         4: return c >= 1 && c <= 23 && !(c inside {7, 8, 13, 18});
         5: return c inside {1, 3, 22};
         default: return 0;
      endcase
   endfunction
   task end_sim;
      if (failures == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Master holds the request until pready is seen at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         failures++;
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
      chk(32'(e), 32'(eexp));
   endtask
   task do_reset;
      rst_b <= 0;
      repeat (2) @(posedge clk);
      rst_b <= 1;
      repeat (3) @(posedge clk);
   endtask
   task setup(input int sel, input int lim);
      do_reset;
      wr(FAR_ADDR_CLASS_SEL, 32'(sel));
      wr(FAR_ADDR_ATT_LIMIT, 32'(lim));
      wr(FAR_ADDR_WAIT_TIME, 32'h0);
   endtask
   task fire_wait(input int c, input logic ti, input logic pon, output bit seen);
      @(posedge clk);
      fire <= 1;
      req <= '{1'b1, 5'(c), ti, pon};
      @(posedge clk);
      fire <= 0;
      seen = 0;
      for (int n = 0; n < 30 && !seen; n++) begin
         @(negedge clk);
         seen = (cmd.restart === 1'b1);
      end
   endtask
   task one_case(input int sel, input int c, input logic ti, input logic pon, input int lim, input bit exp);
      bit seen;
      setup(sel, lim);
      fire_wait(c, ti, pon, seen);
      chk(32'(seen), 32'(exp));
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      int allowed, lim, first, c, r0;
      bit seen;
      do_reset;
      rd_chk(FAR_ADDR_CLASS_SEL, 32'h0, 1'b0);
      rd_chk(FAR_ADDR_ATT_LIMIT, 32'h0, 1'b0);
      wr(FAR_ADDR_WAIT_TIME, 32'h0000_000B);
      rd_chk(FAR_ADDR_WAIT_TIME, 32'h1, 1'b0);
      wr(FAR_ADDR_ATT_LIMIT, 32'h0000_0032);
      rd_chk(FAR_ADDR_ATT_LIMIT, 32'h0, 1'b0);
      wr(FAR_ADDR_SUCC_CNT, 32'h0000_0005);
      rd_chk(FAR_ADDR_SUCC_CNT, 32'h0, 1'b0);
      wr(FAR_ADDR_SUCC_CNT, 32'h0);
      rd_chk(FAR_ADDR_SUCC_CNT, 32'h0, 1'b0);
      rd_chk(8'h18, 32'h0, 1'b1);
      wr(FAR_ADDR_CTRL, 32'h1);
      @(negedge clk);
      chk(32'(act), 32'h1);
      for (int s = 0; s <= 5; s++)
         for (int k = 1; k <= 23; k++)
            one_case(s, k, 1'b0, 1'b0, 1, elig(s, k));
      one_case(0, 17, 1'b0, 1'b1, 1, 0);
      one_case(0, 1, 1'b1, 1'b0, 1, 0);
      one_case(0, 1, 1'b0, 1'b0, 0, 0);
      // Consecutive failed retries until the attempt limit trips
      for (int t = 0; t < 4; t++) begin
         allowed = int'(rnd() % 3) + 1;
         lim = rnd() & 1 ? allowed + 100 : allowed;
         coast <= rnd() & 1 ? 16'h270F : 16'(rnd() % 9999);
         first = int'(rnd() % 23) + 1;
         c = first;
         setup(0, lim);
         r0 = restarts;
         for (int k = 0; k < allowed; k++) begin
            fire_wait(c, 1'b0, 1'b0, seen);
            chk(32'(seen), 32'h1);
            chk(32'(fout), 32'(lim > 100));
            chk(32'(act), 32'h1);
            chk(32'(cmd.flying_restart), 32'(coast != 16'h270F));
            c = int'(rnd() % 23) + 1;
         end
         fire_wait(c, 1'b0, 1'b0, seen);
         chk(32'(seen), 32'h0);
         chk(32'(ltrip), 32'h1);
         chk(32'(fout), 32'h1);
         chk(32'(stored), 32'(first));
         chk(32'(restarts - r0), 32'(allowed));
      end
      end_sim;
   end
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      end_sim;
   end
endmodule
